// *** rst_seq_pkg.sv ***
`default_nettype none
package rst_seq_pkg;
    // clock and time figures
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned FILT_MIN_NS    = 475;
    localparam int unsigned FILT_MAX_NS    = 2000;
    localparam int unsigned FILT_CYC       = (FILT_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned FILT_MAX_CYC   = (FILT_MAX_NS * CLK_MHZ) / 1000;
    // start-up phase lengths in oscillator cycles, warm stretch in peripheral clock rises
    localparam int unsigned OSC_CHECK_CYC  = 1032;
    localparam int unsigned FUSE_LOAD_CYC  = 1160;
    localparam int unsigned PUMP_UP_CYC    = 688;
    localparam int unsigned BANK_UP_CYC    = 617;
    localparam int unsigned POR_STRETCH_CYC = 2256;
    localparam int unsigned WARM_STRETCH_CYC = 32;
    localparam logic [31:0] BOOT_ADDR      = 32'h0000_0000;
    // register byte addresses
    localparam logic [7:0] ADDR_EXC_STAT   = 8'h00;
    localparam logic [7:0] ADDR_GLB_STAT   = 8'h04;
    localparam logic [7:0] ADDR_SEQ_STAT   = 8'h08;
    localparam logic [7:0] ADDR_CTRL       = 8'h0C;
    // flag positions
    localparam int unsigned EXC_POWERUP    = 15;
    localparam int unsigned EXC_WDOG       = 13;
    localparam int unsigned EXC_SELFTEST   = 5;
    localparam int unsigned EXC_SOFT       = 4;
    localparam int unsigned EXC_EXTERNAL   = 3;
    localparam int unsigned GLB_OSC_FAIL   = 0;
    localparam int unsigned GLB_SLIP_LO    = 8;
    localparam int unsigned GLB_SLIP_HI    = 9;
    localparam int unsigned CTRL_SOFT_RST  = 0;
    localparam logic [31:0] EXC_RESET      = 32'h0000_0000;
    localparam logic [31:0] GLB_RESET      = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;

    typedef enum logic [2:0] {
        ST_WAIT  = 3'b000,
        ST_OSC   = 3'b001,
        ST_FUSE  = 3'b010,
        ST_PUMP  = 3'b011,
        ST_BANK  = 3'b100,
        ST_RUN   = 3'b101
    } seq_state_e;

    // reset requests from inside the device
    typedef struct packed {
        logic osc_fail;
        logic pll_slip;
        logic wdog;
        logic selftest;
    } rst_req_s;
endpackage
`default_nettype wire

// *** power_up_reset_sequencer.sv ***
`default_nettype none
module power_up_reset_sequencer #(
    parameter int unsigned FILT_MIN = rst_seq_pkg::FILT_CYC
) (
    input  wire  logic        clk,                // 125 MHz, also oscillator count clock
    input  wire  logic        reset_n,            // synchronous, active low
    input  wire  logic        power_on_reset_n_pin, // pin level, pulldown applied outside
    output logic              power_on_pull_down, // weak pulldown request
    input  wire  logic        io_supply_good,     // i/o supply above threshold
    input  wire  logic        core_supply_good,   // core supply above threshold
    input  wire  logic        warm_reset_pin_i,   // warm reset pin level
    output logic              warm_reset_pin_o,   // pin output value, always low
    output logic              warm_reset_pin_oe,  // high while pulling pin low
    output logic              warm_reset_pull_up, // weak pullup request
    input  wire  logic        peripheral_clock,   // peripheral clock, sampled
    input  wire  rst_seq_pkg::rst_req_s rst_req,  // internal reset requests
    output logic              cpu_reset_n,        // cpu reset, low holds cpu
    output logic [31:0]       cpu_boot_addr,      // first fetch address
    output logic [2:0]        seq_phase,          // current start-up phase
    input  wire  logic        s_axi_awvalid,      // axi4-lite write address
    output logic              s_axi_awready,      // write address ready
    input  wire  logic [7:0]  s_axi_awaddr,       // write byte address
    input  wire  logic        s_axi_wvalid,       // write data valid
    output logic              s_axi_wready,       // write data ready
    input  wire  logic [31:0] s_axi_wdata,        // write data
    input  wire  logic [3:0]  s_axi_wstrb,        // byte enables
    output logic              s_axi_bvalid,       // write response valid
    input  wire  logic        s_axi_bready,       // write response ready
    output logic [1:0]        s_axi_bresp,        // write response
    input  wire  logic        s_axi_arvalid,      // read address valid
    output logic              s_axi_arready,      // read address ready
    input  wire  logic [7:0]  s_axi_araddr,       // read byte address
    output logic              s_axi_rvalid,       // read data valid
    input  wire  logic        s_axi_rready,       // read data ready
    output logic [31:0]       s_axi_rdata,        // read data
    output logic [1:0]        s_axi_rresp         // read response
);
    localparam int unsigned CW = 12;

    // three-stage synchronisers for pins and peripheral clock
    logic [2:0] por_sync_q, warm_sync_q, pclk_sync_q;
    always_ff @(posedge clk)
    begin
        por_sync_q  <= {por_sync_q[1:0], power_on_reset_n_pin};
        warm_sync_q <= {warm_sync_q[1:0], warm_reset_pin_i};
        pclk_sync_q <= {pclk_sync_q[1:0], peripheral_clock};
    end

    // agreed levels from second and third stage
    wire por_agree_low  = ~por_sync_q[1] & ~por_sync_q[2];
    wire por_agree_high = por_sync_q[1] & por_sync_q[2];
    wire warm_agree_low = ~warm_sync_q[1] & ~warm_sync_q[2];
    wire pclk_rise      = pclk_sync_q[1] & ~pclk_sync_q[2];

    // glitch filters: low must last FILT_MIN cycles before it counts
    logic [7:0] por_filt_q, warm_filt_q;
    logic       por_low_q, warm_low_q;
    wire  [7:0] filt_min = FILT_MIN[7:0];
    wire        self_drive;
    always_ff @(posedge clk)
    begin
        if (!reset_n || !por_agree_low)
            por_filt_q <= 8'h00;
        else if (por_filt_q != filt_min)
            por_filt_q <= por_filt_q + 8'h01;
        if (!reset_n || !warm_agree_low || self_drive)
            warm_filt_q <= 8'h00;
        else if (warm_filt_q != filt_min)
            warm_filt_q <= warm_filt_q + 8'h01;
    end

    // filtered power-on and external warm reset levels
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            por_low_q  <= 1'b1;
            warm_low_q <= 1'b0;
        end
        else
        begin
            if (por_filt_q == filt_min)
                por_low_q <= 1'b1;
            else if (por_agree_high)
                por_low_q <= 1'b0;
            warm_low_q <= (warm_filt_q == filt_min);
        end
    end

    // power-on condition from pin and both supplies
    logic soft_rst_q;
    wire por_active = por_low_q | ~io_supply_good | ~core_supply_good;
    wire ext_warm   = warm_low_q;
    wire int_warm   = |rst_req | soft_rst_q;

    // start-up sequencer
    rst_seq_pkg::seq_state_e state_q, state_d;
    logic [CW-1:0] cnt_q;
    wire  [CW-1:0] phase_len =
        (state_q == rst_seq_pkg::ST_OSC)  ? CW'(rst_seq_pkg::OSC_CHECK_CYC) :
        (state_q == rst_seq_pkg::ST_FUSE) ? CW'(rst_seq_pkg::FUSE_LOAD_CYC) :
        (state_q == rst_seq_pkg::ST_PUMP) ? CW'(rst_seq_pkg::PUMP_UP_CYC) :
                                            CW'(rst_seq_pkg::BANK_UP_CYC);
    wire phase_done = (cnt_q == phase_len - CW'(1));

    // next phase selection
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            rst_seq_pkg::ST_WAIT: if (!por_active) state_d = rst_seq_pkg::ST_OSC;
            rst_seq_pkg::ST_OSC:  if (phase_done) state_d = rst_seq_pkg::ST_FUSE;
            rst_seq_pkg::ST_FUSE: if (phase_done) state_d = rst_seq_pkg::ST_PUMP;
            rst_seq_pkg::ST_PUMP: if (phase_done) state_d = rst_seq_pkg::ST_BANK;
            rst_seq_pkg::ST_BANK: if (phase_done) state_d = rst_seq_pkg::ST_RUN;
            rst_seq_pkg::ST_RUN:  state_d = rst_seq_pkg::ST_RUN;
            default:              state_d = rst_seq_pkg::ST_WAIT;
        endcase
    end

    // phase state and counter
    always_ff @(posedge clk)
    begin
        if (!reset_n || por_active)
        begin
            state_q <= rst_seq_pkg::ST_WAIT;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= (state_d != state_q) ? '0 : cnt_q + CW'(1);
        end
    end

    // warm reset stretch: por release or other cause
    logic [CW-1:0] por_str_q;
    logic [5:0]    warm_str_q;
    logic          warm_busy_q;
    always_ff @(posedge clk)
    begin
        if (!reset_n || por_active)
            por_str_q <= CW'(rst_seq_pkg::POR_STRETCH_CYC);
        else if (por_str_q != '0)
            por_str_q <= por_str_q - CW'(1);
        if (!reset_n)
        begin
            warm_str_q  <= '0;
            warm_busy_q <= 1'b0;
        end
        else if (int_warm || ext_warm)
        begin
            warm_str_q  <= 6'(rst_seq_pkg::WARM_STRETCH_CYC + 1); // extra rise: partial period
            warm_busy_q <= 1'b1;
        end
        else if (warm_str_q != '0)
        begin
            if (pclk_rise)
                warm_str_q <= warm_str_q - 6'd1;
        end
        else
            warm_busy_q <= 1'b0;
    end

    // pin drive: open drain, low only
    assign self_drive = por_active | (por_str_q != '0) | warm_busy_q;
    logic oe_q, cpu_rst_n_q;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            oe_q        <= 1'b1;
            cpu_rst_n_q <= 1'b0;
        end
        else
        begin
            oe_q        <= self_drive;
            cpu_rst_n_q <= (state_q == rst_seq_pkg::ST_RUN) & ~self_drive;
        end
    end
    assign warm_reset_pin_oe  = oe_q;
    assign warm_reset_pin_o   = 1'b0;
    assign warm_reset_pull_up = 1'b1;
    assign power_on_pull_down = 1'b1;
    assign cpu_reset_n        = cpu_rst_n_q;
    assign cpu_boot_addr      = rst_seq_pkg::BOOT_ADDR;
    assign seq_phase          = state_q;

    // decode results used by the handshake logic
    wire        wr_hit;
    wire        rd_hit;
    wire [31:0] rd_data;

    // axi4-lite handshakes
    logic aw_q, w_q, bvalid_q, arvalid_q, rvalid_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0]  wstrb_q;
    logic [1:0]  bresp_q, rresp_q;
    wire do_write = aw_q & w_q & ~bvalid_q;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
            bresp_q  <= rst_seq_pkg::RESP_OKAY;
            rresp_q  <= rst_seq_pkg::RESP_OKAY;
            rdata_q  <= '0;
        end
        else
        begin
            if (s_axi_awvalid && !aw_q)
            begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_q)
            begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_q <= 1'b0;
                w_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? rst_seq_pkg::RESP_OKAY : rst_seq_pkg::RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
            if (s_axi_arvalid && !rvalid_q)
            begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_data;
                rresp_q  <= rd_hit ? rst_seq_pkg::RESP_OKAY : rst_seq_pkg::RESP_SLVERR;
            end
            else if (rvalid_q && s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end
    assign s_axi_awready = ~aw_q;
    assign s_axi_wready  = ~w_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // address decode
    wire wr_exc  = awaddr_q == rst_seq_pkg::ADDR_EXC_STAT;
    wire wr_glb  = awaddr_q == rst_seq_pkg::ADDR_GLB_STAT;
    wire wr_ctrl = awaddr_q == rst_seq_pkg::ADDR_CTRL;
    assign wr_hit = wr_exc | wr_glb | wr_ctrl | (awaddr_q == rst_seq_pkg::ADDR_SEQ_STAT);
    assign rd_hit = (s_axi_araddr == rst_seq_pkg::ADDR_EXC_STAT) |
                   (s_axi_araddr == rst_seq_pkg::ADDR_GLB_STAT) |
                   (s_axi_araddr == rst_seq_pkg::ADDR_SEQ_STAT) |
                   (s_axi_araddr == rst_seq_pkg::ADDR_CTRL);
    logic [31:0] exc_q, glb_q;
    assign rd_data =
        (s_axi_araddr == rst_seq_pkg::ADDR_EXC_STAT) ? exc_q :
        (s_axi_araddr == rst_seq_pkg::ADDR_GLB_STAT) ? glb_q :
        (s_axi_araddr == rst_seq_pkg::ADDR_SEQ_STAT) ?
            {28'h000_0000, cpu_rst_n_q, state_q} :
        (s_axi_araddr == rst_seq_pkg::ADDR_CTRL) ? {31'h0000_0000, soft_rst_q} : 32'h0000_0000;

    // write-one-to-clear masks, byte enabled
    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [31:0] exc_clr = (do_write && wr_exc) ? (wdata_q & wmask) : 32'h0000_0000;
    wire [31:0] glb_clr = (do_write && wr_glb) ? (wdata_q & wmask) : 32'h0000_0000;

    // event set vectors
    logic por_seen_q;
    wire  por_rise = por_active & ~por_seen_q;
    logic [31:0] exc_set, glb_set;
    always_comb
    begin
        exc_set = 32'h0000_0000;
        glb_set = 32'h0000_0000;
        exc_set[rst_seq_pkg::EXC_POWERUP]  = por_rise;
        exc_set[rst_seq_pkg::EXC_WDOG]     = rst_req.wdog;
        exc_set[rst_seq_pkg::EXC_SELFTEST] = rst_req.selftest;
        exc_set[rst_seq_pkg::EXC_SOFT]     = soft_rst_q;
        exc_set[rst_seq_pkg::EXC_EXTERNAL] = ext_warm;
        glb_set[rst_seq_pkg::GLB_OSC_FAIL] = rst_req.osc_fail;
        glb_set[rst_seq_pkg::GLB_SLIP_LO]  = rst_req.pll_slip;
        glb_set[rst_seq_pkg::GLB_SLIP_HI]  = rst_req.pll_slip;
    end

    // sticky cause flags, set beats clear, warm reset leaves them
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            exc_q      <= rst_seq_pkg::EXC_RESET;
            glb_q      <= rst_seq_pkg::GLB_RESET;
            por_seen_q <= 1'b0;
            soft_rst_q <= 1'b0;
        end
        else
        begin
            exc_q      <= (exc_q & ~exc_clr) | exc_set;
            glb_q      <= (glb_q & ~glb_clr) | glb_set;
            por_seen_q <= por_active;
            soft_rst_q <= do_write & wr_ctrl & wstrb_q[0] &
                          wdata_q[rst_seq_pkg::CTRL_SOFT_RST];
        end
    end

    // cycle counter for cpu release check
    logic [CW-1:0] since_q;
    always_ff @(posedge clk)
    begin
        if (!reset_n || state_q == rst_seq_pkg::ST_WAIT)
            since_q <= '0;
        else if (since_q != {CW{1'b1}})
            since_q <= since_q + CW'(1);
    end

    chk_cpu_release_order: assert property (@(posedge clk) disable iff (!reset_n)
        cpu_rst_n_q |-> since_q >= CW'(3497))
        else $error("cpu released before start-up phases finished");
    chk_seq_needs_power: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == rst_seq_pkg::ST_WAIT && por_active) |=> state_q == rst_seq_pkg::ST_WAIT)
        else $error("sequence left wait while power-on reset active");
    chk_phase_osc_len: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(state_q == rst_seq_pkg::ST_FUSE) |-> $past(cnt_q) == CW'(1031))
        else $error("oscillator phase length wrong");
    chk_warm_drive_por: assert property (@(posedge clk) disable iff (!reset_n)
        por_active |=> oe_q)
        else $error("warm reset pin not driven during power-on reset");
    // cycles since the power-on condition went away, for the stretch check
    logic [CW-1:0] por_rel_q;
    always_ff @(posedge clk)
    begin
        if (!reset_n || por_active)
            por_rel_q <= '0;
        else if (por_rel_q != {CW{1'b1}})
            por_rel_q <= por_rel_q + CW'(1);
    end

    chk_por_stretch: assert property (@(posedge clk) disable iff (!reset_n)
        (!por_active && por_rel_q < CW'(rst_seq_pkg::POR_STRETCH_CYC)) |-> oe_q)
        else $error("warm reset released too early after power-on");
    chk_warm_stretch: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(rst_req.wdog) |-> ##2 oe_q [*8])
        else $error("warm reset not held after internal cause");
    chk_sticky_por: assert property (@(posedge clk) disable iff (!reset_n)
        por_rise |=> exc_q[rst_seq_pkg::EXC_POWERUP])
        else $error("power-up flag not set");
    chk_slip_pair: assert property (@(posedge clk) disable iff (!reset_n)
        glb_q[rst_seq_pkg::GLB_SLIP_LO] == glb_q[rst_seq_pkg::GLB_SLIP_HI] ||
        $past(glb_clr) != 32'h0000_0000)
        else $error("slip flag bits disagree");
    chk_ext_flag: assert property (@(posedge clk) disable iff (!reset_n)
        ext_warm |=> exc_q[rst_seq_pkg::EXC_EXTERNAL] ##1 oe_q)
        else $error("external warm reset not flagged");
endmodule
`default_nettype wire

// *** board_reset_model.sv ***
`default_nettype none
module board_reset_model #(
    parameter int unsigned HOLD_CYC = 200 // supervisor hold, shortened from 1 ms
) (
    input  wire logic clk,         // bench clock
    input  wire logic supplies_ok, // both rails in range
    input  wire logic por_glitch,  // extra low pulse on power-on pin
    input  wire logic warm_force,  // board pulls warm reset low
    input  wire logic warm_oe,     // device pulls warm reset low
    output logic      por_n,       // power-on reset pin level
    output logic      supply_good, // both supplies good
    output logic      warm_level,  // resolved warm reset wire
    output logic      per_clk      // peripheral clock, clk / 4
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned hold = 0;
    logic [1:0]  div  = '0;
    // supervisor keeps the pin low while rails are bad and for a hold after
    always @(posedge clk)
    begin
        hold <= !supplies_ok ? 0 : (hold < HOLD_CYC ? hold + 1 : hold);
        div  <= div + 2'h1;
    end
    assign por_n       = supplies_ok && (hold == HOLD_CYC) && !por_glitch;
    assign supply_good = supplies_ok;
    // open-drain wire, board pullup wins when nobody pulls low
    assign warm_level  = !(warm_oe || warm_force);
    assign per_clk     = div[1];
endmodule
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] OK    = rst_seq_pkg::RESP_OKAY;
    localparam logic [1:0] ER    = rst_seq_pkg::RESP_SLVERR;
    localparam logic [7:0] A_EXC = rst_seq_pkg::ADDR_EXC_STAT;
    localparam logic [7:0] A_GLB = rst_seq_pkg::ADDR_GLB_STAT;
    logic        clk = '0, reset_n = '0, sup_ok = '0, por_gl = '0, warm_f = '0;
    logic        awv = '0, wv = '0, br = '0, arv = '0, rr = '0;
    logic        por_n, sup_good, warm_lv, per_clk, pd, pu, wo, oe, cpu_rn, awr, wr, bv, arr, rv;
    logic [7:0]  awa = '0, ara = '0;
    logic [3:0]  ws = '0;
    logic [2:0]  ph, last_ph;
    logic [1:0]  bresp, rresp, exp_b[$];
    logic [31:0] wd = '0, rd, boot, len, ep, exc = '0, glb = '0, exp_p[$];
    logic [33:0] er, exp_r[$];
    rst_seq_pkg::rst_req_s req = '0;
    int          fail_count = 0, tests_run = 0, cyc = 0, seed = 88, n;
    logic [31:0] exc_tab [5] = '{'0, '0, 32'h0000_0001 << rst_seq_pkg::EXC_WDOG,
        32'h0000_0001 << rst_seq_pkg::EXC_SELFTEST, 32'h0000_0001 << rst_seq_pkg::EXC_SOFT};
    logic [31:0] glb_tab [5] = '{32'h0000_0001 << rst_seq_pkg::GLB_OSC_FAIL,
        32'h0000_0003 << rst_seq_pkg::GLB_SLIP_LO, '0, '0, '0};
    power_up_reset_sequencer DUT (
        .clk(clk), .reset_n(reset_n), .power_on_reset_n_pin(por_n), .power_on_pull_down(pd),
        .io_supply_good(sup_good), .core_supply_good(sup_good), .warm_reset_pin_i(warm_lv),
        .warm_reset_pin_o(wo), .warm_reset_pin_oe(oe), .warm_reset_pull_up(pu),
        .peripheral_clock(per_clk), .rst_req(req), .cpu_reset_n(cpu_rn),
        .cpu_boot_addr(boot), .seq_phase(ph), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp));
    board_reset_model #(.HOLD_CYC(200)) board (
        .clk(clk), .supplies_ok(sup_ok), .por_glitch(por_gl), .warm_force(warm_f),
        .warm_oe(oe), .por_n(por_n), .supply_good(sup_good), .warm_level(warm_lv),
        .per_clk(per_clk));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            fail_count++;
            $display("ERROR %0t ns: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic step();
        @(posedge clk);
        n++;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] r);
        exp_b.push_back(r);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        n = 0;
        while (!(bv && br))
        begin
            step();
            if (awv && awr)
                awv <= 1'b0;
            if (wv && wr)
                wv <= 1'b0;
        end
        br <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_r.push_back({r, d});
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        n = 0;
        while (!(rv && rr))
        begin
            step();
            if (arv && arr)
                arv <= 1'b0;
        end
        rr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic push_seq();
        exp_p.push_back({16'hFFFF, 13'h0000, rst_seq_pkg::ST_OSC});
        exp_p.push_back({16'(rst_seq_pkg::OSC_CHECK_CYC), 13'h0000, rst_seq_pkg::ST_FUSE});
        exp_p.push_back({16'(rst_seq_pkg::FUSE_LOAD_CYC), 13'h0000, rst_seq_pkg::ST_PUMP});
        exp_p.push_back({16'(rst_seq_pkg::PUMP_UP_CYC), 13'h0000, rst_seq_pkg::ST_BANK});
        exp_p.push_back({16'(rst_seq_pkg::BANK_UP_CYC), 13'h0000, rst_seq_pkg::ST_RUN});
    endtask
    // power-on release, stretch of the warm pin, then wait for the cpu
    task automatic run_up();
        n = 0;
        while (por_n !== 1'b1 && n < 9000) step();
        check(32'(oe), 32'h0000_0001);
        check({29'h0, pd, pu, wo}, 32'h0000_0006);
        n = 0;
        while (oe === 1'b1 && n < 9000) step();
        check(32'(n >= rst_seq_pkg::POR_STRETCH_CYC), 32'h0000_0001);
        while (ph !== rst_seq_pkg::ST_RUN && n < 9000) step();
        repeat (2) @(posedge clk);
        check(32'(cpu_rn), 32'h0000_0001);
        check(boot, rst_seq_pkg::BOOT_ADDR);
    endtask
    task automatic stretch();
        n = 0;
        while (oe !== 1'b1 && n < 8) step();
        check(32'(oe), 32'h0000_0001);
        n = 0;
        while (oe === 1'b1 && n < 2000) step();
        check(32'(n >= rst_seq_pkg::WARM_STRETCH_CYC * 4), 32'h0000_0001);
    endtask
    task automatic glitch(input logic on_por, input int k);
        por_gl <= on_por;
        warm_f <= !on_por;
        repeat (k) @(posedge clk);
        por_gl <= 1'b0;
        warm_f <= 1'b0;
    endtask
    initial
    begin
        forever #4 clk = ~clk;
    end
    // watcher: each response or phase change retires the oldest note
    always @(posedge clk)
    begin
        if (bv && br)
            check(32'(bresp), 32'(exp_b.size() > 0 ? exp_b.pop_front() : 2'h1));
        if (rv && rr)
        begin
            er = exp_r.size() > 0 ? exp_r.pop_front() : {2'h1, 32'h0000_0000};
            check(rd, er[31:0]);
            check(32'(rresp), 32'(er[33:32]));
        end
        if (!reset_n)
            last_ph <= rst_seq_pkg::ST_WAIT;
        else if (ph !== last_ph)
        begin
            ep = exp_p.size() > 0 ? exp_p.pop_front() : 32'hFFFF_FFFF;
            check(32'(ph), 32'(ep[2:0]));
            if (ep[31:16] != 16'hFFFF)
                check(len, 32'(ep[31:16]));
            last_ph <= ph;
            len <= 32'h0000_0001;
        end
        else
            len <= len + 32'h0000_0001;
    end
    // cycle ceiling against a hang
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            end_of_test();
        end
    end
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        push_seq();
        sup_ok <= 1'b1;
        run_up();
        axi_rd(A_EXC, 32'h0000_8000, OK);
        axi_rd(A_GLB, 32'h0000_0000, OK);
        axi_rd(rst_seq_pkg::ADDR_SEQ_STAT, {28'h000_0000, 1'b1, rst_seq_pkg::ST_RUN}, OK);
        axi_wr(8'h10, $random(seed), 4'hF, ER);
        axi_rd(8'h10, 32'h0000_0000, ER);
        axi_wr(A_EXC, 32'h0000_8000, 4'h1, OK);
        axi_rd(A_EXC, 32'h0000_8000, OK);
        axi_wr(A_EXC, 32'h0000_8000, 4'h2, OK);
        axi_rd(A_EXC, 32'h0000_0000, OK);
        for (int i = 0; i < 5; i++)
        begin
            if (i < 4)
                req <= rst_seq_pkg::rst_req_s'(4'h8 >> i);
            else
                axi_wr(rst_seq_pkg::ADDR_CTRL, 32'h0000_0001 << rst_seq_pkg::CTRL_SOFT_RST,
                       4'hF, OK);
            @(posedge clk);
            req <= '0;
            stretch();
            exc = exc | exc_tab[i];
            glb = glb | glb_tab[i];
            axi_rd(A_EXC, exc, OK);
            axi_rd(A_GLB, glb, OK);
        end
        axi_wr(A_EXC, 32'hFFFF_FFFF, 4'hF, OK);
        axi_wr(A_GLB, 32'hFFFF_FFFF, 4'hF, OK);
        axi_rd(A_GLB, 32'h0000_0000, OK);
        glitch(1'b0, 10 + ($random(seed) & 31));
        repeat (400) @(posedge clk);
        axi_rd(A_EXC, 32'h0000_0000, OK);
        glitch(1'b0, 300);
        repeat (400) @(posedge clk);
        axi_rd(A_EXC, 32'h0000_0008, OK);
        glitch(1'b1, 10 + ($random(seed) & 31));
        repeat (200) @(posedge clk);
        exp_p.push_back({16'hFFFF, 13'h0000, rst_seq_pkg::ST_WAIT});
        push_seq();
        glitch(1'b1, 300);
        run_up();
        axi_rd(A_EXC, 32'h0000_8008, OK);
        check(32'(exp_p.size() + exp_r.size() + exp_b.size()), 32'h0000_0000);
        end_of_test();
    end
endmodule
`default_nettype wire
